// ===== design/lssfc_pkg.sv
// Package for the display supply soft-start and fault controller.
// Assumes a single 1.6 MHz switching clock domain; comparator flags arrive synchronous.
package lssfc_pkg;
    // Soft-start step lengths in switching clock cycles
    localparam int unsigned STEP_CYCLES_STD = 1024;
    localparam int unsigned STEP_CYCLES_EXT = 2048;
    localparam int unsigned STEP_CNT_W      = 12;

    // Current limit codes, in fifths of the nominal limit
    localparam logic [2:0] ILIM_TWO_FIFTHS   = 3'h2;
    localparam logic [2:0] ILIM_THREE_FIFTHS = 3'h3;
    localparam logic [2:0] ILIM_FULL         = 3'h5;
    localparam logic [2:0] ILIM_OFF          = 3'h0;

    typedef enum logic [2:0] {
        LSSFC_IDLE     = 3'b000,
        LSSFC_BOOST    = 3'b001,
        LSSFC_NEG_PUMP = 3'b010,
        LSSFC_POS_PUMP = 3'b011,
        LSSFC_RUN      = 3'b100,
        LSSFC_FAULT    = 3'b101
    } lssfc_state_t;

    // Comparator flags from the analogue side, high when the condition holds
    typedef struct packed {
        logic boost_ov;        // Boost output above overvoltage level
        logic boost_pg;        // Boost output above power-good level
        logic neg_pg;          // Negative pump within power-good band
        logic pos_pg;          // Positive pump above power-good level
        logic over_temp;       // Die at thermal shutdown level
        logic reg_low;         // Regulator output below foldback level
        logic backplane_ref_ok; // Backplane reference input above enable level
    } lssfc_flags_t;

    // Enables towards the analogue power stages
    typedef struct packed {
        logic boost_en;
        logic boost_switch;
        logic neg_pump_en;
        logic pos_pump_en;
        logic backplane_en;
        logic regulator_en;
        logic reg_foldback;
    } lssfc_rails_t;
endpackage : lssfc_pkg

// ===== design/lssfc_ilim_steps.sv
// Boost current limit stepper used during soft start.
// Assumes start is held high for as long as the boost converter is up.
`timescale 1ns/1ps
module lssfc_ilim_steps #(
    parameter int unsigned STEP_STD = lssfc_pkg::STEP_CYCLES_STD,
    parameter int unsigned STEP_EXT = lssfc_pkg::STEP_CYCLES_EXT
) (
    input  wire logic       CLK,
    input  wire logic       NRST,
    input  wire logic       start,
    input  wire logic       extended,
    output logic [2:0]      ilim
);
    logic [lssfc_pkg::STEP_CNT_W-1:0] cnt;
    logic [1:0]                       step;
    logic [lssfc_pkg::STEP_CNT_W-1:0] last;

    assign last = extended ? lssfc_pkg::STEP_CNT_W'(STEP_EXT - 1)
                           : lssfc_pkg::STEP_CNT_W'(STEP_STD - 1);

    // Dropping start returns to the first step, so every restart is soft
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            cnt  <= '0;
            step <= 2'h0;
        end
        else if (!start)
        begin
            cnt  <= '0;
            step <= 2'h0;
        end
        else if (step != 2'h2)
        begin
            if (cnt == last)
            begin
                cnt  <= '0;
                step <= step + 2'h1;
            end
            else
            begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            ilim <= lssfc_pkg::ILIM_OFF;
        else if (!start)
            ilim <= lssfc_pkg::ILIM_OFF;
        // Follows step one edge late, so each level stands a full step length
        else if (step == 2'h0)
            ilim <= lssfc_pkg::ILIM_TWO_FIFTHS;
        else if (step == 2'h1)
            ilim <= lssfc_pkg::ILIM_THREE_FIFTHS;
        else
            ilim <= lssfc_pkg::ILIM_FULL;
    end

    AST_ILIM_START_LOW: assert property (@(posedge CLK) disable iff (!NRST)
        $rose(start) |=> ilim == lssfc_pkg::ILIM_TWO_FIFTHS)
        else $error("Current limit did not start at two fifths");
    AST_ILIM_NEVER_DROPS: assert property (@(posedge CLK) disable iff (!NRST)
        start && $past(start) && ilim != $past(ilim) |-> ilim > $past(ilim))
        else $error("Current limit stepped down during soft start");
endmodule : lssfc_ilim_steps

// ===== design/lssfc_ctrl.sv
// Soft-start sequencing and latched fault shutdown for a triple-rail display supply.
// Assumes analogue comparators give synchronous flags; NRST is the input lockout.
`timescale 1ns/1ps
module lssfc_ctrl #(
    parameter bit FAULT_PROTECT = 1'b1
) (
    input  wire logic                    CLK,
    input  wire logic                    NRST,
    input  wire logic                    MAIN_ENABLE,
    input  wire logic                    REGULATOR_ENABLE,
    input  wire lssfc_pkg::lssfc_flags_t FLAGS,
    output lssfc_pkg::lssfc_rails_t      RAILS,
    output logic [2:0]                   BOOST_ILIM,
    output logic                         FAULT_LATCHED,
    output logic                         SOFT_START_DONE
);
    lssfc_pkg::lssfc_state_t state;
    lssfc_pkg::lssfc_state_t next_state;
    logic                    pg_fault;
    logic                    fault;
    logic                    boost_up;
    logic [2:0]              ilim;

    // Unprotected variant has only the thermal trip as a shutdown cause
    assign pg_fault = FAULT_PROTECT &&
                      ((!FLAGS.boost_pg)
                       || (state >= lssfc_pkg::LSSFC_POS_PUMP && !FLAGS.neg_pg)
                       || (state == lssfc_pkg::LSSFC_RUN && !FLAGS.pos_pg));
    // Power-good is only judged once the rail has been brought up
    assign fault = FLAGS.over_temp
                   || (pg_fault && state >= lssfc_pkg::LSSFC_NEG_PUMP);

    always_comb
    begin
        next_state = state;
        case (state)
            lssfc_pkg::LSSFC_IDLE:
                if (MAIN_ENABLE)
                    next_state = lssfc_pkg::LSSFC_BOOST;
            lssfc_pkg::LSSFC_BOOST:
                if (FLAGS.boost_pg)
                    next_state = lssfc_pkg::LSSFC_NEG_PUMP;
            lssfc_pkg::LSSFC_NEG_PUMP:
                if (FLAGS.neg_pg)
                    next_state = lssfc_pkg::LSSFC_POS_PUMP;
            lssfc_pkg::LSSFC_POS_PUMP:
                if (FLAGS.pos_pg)
                    next_state = lssfc_pkg::LSSFC_RUN;
            lssfc_pkg::LSSFC_RUN:
                next_state = lssfc_pkg::LSSFC_RUN;
            lssfc_pkg::LSSFC_FAULT:
                next_state = lssfc_pkg::LSSFC_FAULT;
            default:
                next_state = lssfc_pkg::LSSFC_IDLE;
        endcase
        if (state != lssfc_pkg::LSSFC_IDLE && state != lssfc_pkg::LSSFC_FAULT && fault)
            next_state = lssfc_pkg::LSSFC_FAULT;
        if (!MAIN_ENABLE)
            next_state = lssfc_pkg::LSSFC_IDLE;
    end

    // Lockout is the asynchronous reset, so a supply dip clears the latch too
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            state <= lssfc_pkg::LSSFC_IDLE;
        else
            state <= next_state;
    end

    assign boost_up = state != lssfc_pkg::LSSFC_IDLE && state != lssfc_pkg::LSSFC_FAULT;

    lssfc_ilim_steps #(
        .STEP_STD (lssfc_pkg::STEP_CYCLES_STD),
        .STEP_EXT (lssfc_pkg::STEP_CYCLES_EXT)
    ) u_steps (
        .CLK      (CLK),
        .NRST     (NRST),
        .start    (boost_up),
        .extended (!FAULT_PROTECT),
        .ilim     (ilim)
    );

    assign BOOST_ILIM = ilim;

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            RAILS           <= '0;
            FAULT_LATCHED   <= 1'b0;
            SOFT_START_DONE <= 1'b0;
        end
        else
        begin
            RAILS.boost_en     <= boost_up;
            RAILS.boost_switch <= boost_up && !FLAGS.boost_ov;
            RAILS.neg_pump_en  <= state >= lssfc_pkg::LSSFC_NEG_PUMP
                                  && state != lssfc_pkg::LSSFC_FAULT;
            RAILS.pos_pump_en  <= state >= lssfc_pkg::LSSFC_POS_PUMP
                                  && state != lssfc_pkg::LSSFC_FAULT;
            RAILS.backplane_en <= state == lssfc_pkg::LSSFC_RUN
                                  && FLAGS.backplane_ref_ok;
            RAILS.regulator_en <= REGULATOR_ENABLE;
            RAILS.reg_foldback <= REGULATOR_ENABLE && FLAGS.reg_low;
            FAULT_LATCHED      <= state == lssfc_pkg::LSSFC_FAULT;
            SOFT_START_DONE    <= ilim == lssfc_pkg::ILIM_FULL;
        end
    end

    AST_OT_SHUTDOWN: assert property (@(posedge CLK) disable iff (!NRST)
        MAIN_ENABLE && boost_up && FLAGS.over_temp
        |=> state == lssfc_pkg::LSSFC_FAULT ##1 !RAILS.boost_en)
        else $error("Over-temperature did not shut the rails down");
    AST_BOOST_PG_FAULT: assert property (@(posedge CLK) disable iff (!NRST)
        FAULT_PROTECT && MAIN_ENABLE && state == lssfc_pkg::LSSFC_RUN && !FLAGS.boost_pg
        |=> state == lssfc_pkg::LSSFC_FAULT)
        else $error("Boost power-good loss ignored");
    AST_NEG_PG_FAULT: assert property (@(posedge CLK) disable iff (!NRST)
        FAULT_PROTECT && MAIN_ENABLE && state == lssfc_pkg::LSSFC_RUN && !FLAGS.neg_pg
        |=> state == lssfc_pkg::LSSFC_FAULT)
        else $error("Negative pump shortfall ignored");
    AST_POS_PG_FAULT: assert property (@(posedge CLK) disable iff (!NRST)
        FAULT_PROTECT && MAIN_ENABLE && state == lssfc_pkg::LSSFC_RUN && !FLAGS.pos_pg
        |=> state == lssfc_pkg::LSSFC_FAULT)
        else $error("Positive pump shortfall ignored");
    AST_NO_PG_SHUTDOWN: assert property (@(posedge CLK) disable iff (!NRST)
        !FAULT_PROTECT && !FLAGS.over_temp && state != lssfc_pkg::LSSFC_FAULT
        |=> state != lssfc_pkg::LSSFC_FAULT)
        else $error("Unprotected variant shut down on power-good loss");
    AST_OV_GATES_SWITCH: assert property (@(posedge CLK) disable iff (!NRST)
        FLAGS.boost_ov |=> !RAILS.boost_switch)
        else $error("Boost switched while above overvoltage level");
    AST_LATCH_HOLDS: assert property (@(posedge CLK) disable iff (!NRST)
        state == lssfc_pkg::LSSFC_FAULT && MAIN_ENABLE
        |=> state == lssfc_pkg::LSSFC_FAULT)
        else $error("Fault latch left without enable low");
    AST_ENABLE_CLEARS: assert property (@(posedge CLK) disable iff (!NRST)
        !MAIN_ENABLE |=> state == lssfc_pkg::LSSFC_IDLE ##1 !FAULT_LATCHED)
        else $error("Enable low did not clear the fault");
    AST_SEQ_ORDER: assert property (@(posedge CLK) disable iff (!NRST)
        RAILS.pos_pump_en |-> RAILS.neg_pump_en && RAILS.boost_en)
        else $error("Positive pump enabled out of order");
    AST_REG_INDEPENDENT: assert property (@(posedge CLK) disable iff (!NRST)
        REGULATOR_ENABLE |=> RAILS.regulator_en)
        else $error("Regulator did not follow its own enable");
endmodule : lssfc_ctrl

// ===== test/lssfc_analog_model.sv
// Stand-in for the power stages: power-good rises a set delay after a rail is enabled.
// Assumes the bench drives the other comparator levels and any forced dropout.
`timescale 1ns/1ps
module lssfc_analog_model (
    input  wire logic                    CLK,
    input  wire logic                    NRST,
    input  wire lssfc_pkg::lssfc_rails_t RAILS,
    input  wire logic [3:0]              DLY,
    input  wire logic [2:0]              DROP,
    input  wire logic [3:0]              LEVELS,
    output lssfc_pkg::lssfc_flags_t      FLAGS
);
    logic [3:0] cnt [3];
    logic [2:0] en;
    logic [2:0] up;
    assign en = {RAILS.boost_en, RAILS.neg_pump_en, RAILS.pos_pump_en};
    // A disabled rail discharges, so its power-good reads low and never holds the last value
    always_ff @(posedge CLK or negedge NRST)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (!NRST || !en[i])
                cnt[i] <= 4'h0;
            else if (cnt[i] != DLY)
                cnt[i] <= cnt[i] + 4'h1;
        end
    end
    for (genvar g = 0; g < 3; g++)
    begin : g_up
        assign up[g] = en[g] && (cnt[g] == DLY);
    end
    assign FLAGS = {LEVELS[3], up & ~DROP, LEVELS[2:0]};
endmodule : lssfc_analog_model

// ===== test/test_lssfc_ctrl.sv
// Bench for the supply controller: protected and extended-start variants side by side.
// Assumes the stand-in model drives the comparator flags of both instances.
`timescale 1ns/1ps
module test_lssfc_ctrl;
    typedef struct packed {
        int unsigned at;
        logic [14:0] val;
        logic [14:0] msk;
    } lssfc_note_t;
    logic CLK, NRST, MAIN_ENABLE, REGULATOR_ENABLE, FAULT_LATCHED, SOFT_START_DONE, fault_ext;
    logic [2:0] BOOST_ILIM, ilim_ext, DROP;
    logic [3:0] DLY, LEVELS;
    logic [15:0] rnd;
    logic [14:0] snap;
    logic [14:0] rv;
    lssfc_pkg::lssfc_flags_t FLAGS;
    lssfc_pkg::lssfc_rails_t RAILS;
    lssfc_note_t notes[$];
    int unsigned cyc = 0;
    int unsigned n_fail = 0;
    int unsigned check_count = 0;
    int unsigned ss_dt[7] = '{3, 1026, 1027, 2050, 2051, 4098, 4099};
    logic [7:0] ss_val[7] = '{8'h44, 8'h44, 8'h64, 8'h64, 8'hA6, 8'hA6, 8'hAA};

    lssfc_ctrl #(.FAULT_PROTECT(1'b1)) dut (.CLK(CLK), .NRST(NRST), .MAIN_ENABLE(MAIN_ENABLE),
        .REGULATOR_ENABLE(REGULATOR_ENABLE), .FLAGS(FLAGS), .RAILS(RAILS),
        .BOOST_ILIM(BOOST_ILIM), .FAULT_LATCHED(FAULT_LATCHED),
        .SOFT_START_DONE(SOFT_START_DONE));
    lssfc_ctrl #(.FAULT_PROTECT(1'b0)) dut_ext (.CLK(CLK), .NRST(NRST),
        .MAIN_ENABLE(MAIN_ENABLE), .REGULATOR_ENABLE(REGULATOR_ENABLE), .FLAGS(FLAGS),
        .RAILS(), .BOOST_ILIM(ilim_ext), .FAULT_LATCHED(fault_ext), .SOFT_START_DONE());
    lssfc_analog_model model (.CLK(CLK), .NRST(NRST), .RAILS(RAILS), .DLY(DLY),
        .DROP(DROP), .LEVELS(LEVELS), .FLAGS(FLAGS));
    assign snap = {RAILS, BOOST_ILIM, FAULT_LATCHED, ilim_ext, fault_ext};

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    // Rails expected in the run state, given the regulator inputs
    function automatic logic [14:0] run_val(input logic sw);
        return {1'b1, sw, 2'h3, LEVELS[0], REGULATOR_ENABLE, REGULATOR_ENABLE & LEVELS[1],
                8'h0};
    endfunction : run_val

    // Call just after a rising edge; dt counts edges from that one, plus one
    task automatic note(input int unsigned dt, input logic [14:0] v, input logic [14:0] m);
        notes.push_back('{cyc + dt, v, m});
    endtask : note

    task automatic compare_out(input lssfc_note_t n);
        check_count++;
        if (((snap & n.msk) !== (n.val & n.msk)) || (n.at != cyc))
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: outputs %h expected %h", $time, snap, n.val);
        end
    endtask : compare_out

    // Call off the clock edge, where the flag has settled
    task automatic compare_done(input logic exp);
        check_count++;
        if (SOFT_START_DONE !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: soft start done %b expected %b", $time,
                     SOFT_START_DONE, exp);
        end
    endtask : compare_done

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    always @(posedge CLK)
        cyc <= cyc + 1;

    always @(negedge CLK)
    begin
        while (notes.size() != 0 && notes[0].at <= cyc)
        begin
            compare_out(notes[0]);
            void'(notes.pop_front());
        end
    end

    initial
    begin
        repeat (20000) @(posedge CLK);
        n_fail++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        give_verdict();
    end

    initial
    begin
        rnd = lfsr(16'hD090);
        NRST = 1'b0;
        MAIN_ENABLE = 1'b0;
        REGULATOR_ENABLE = rnd[4];
        DLY = rnd[3:0];
        DROP = 3'h0;
        LEVELS = {2'b00, rnd[5], 1'b1};
        repeat (2) @(posedge CLK);
        NRST <= 1'b1;
        @(posedge CLK);
        MAIN_ENABLE <= 1'b1;
        note(3, 15'h4000, 15'h5C00);
        foreach (ss_dt[i]) note(ss_dt[i], {7'h40, ss_val[i]}, 15'h40FF);
        repeat (2050) @(posedge CLK);
        @(negedge CLK);
        compare_done(1'b0);
        repeat (2050) @(posedge CLK);
        note(1, run_val(1'b1) | 15'h00AA, 15'h7FFF);
        @(negedge CLK);
        compare_done(1'b1);
        $display("soft start test done");
        for (int k = 0; k < 4; k++)
        begin
            @(posedge CLK);
            if (k < 3)
                DROP <= 3'h4 >> k;
            else
                LEVELS[2] <= 1'b1;
            note(1, run_val(1'b1), 15'h7F00);
            rv = run_val(1'b1);
            note(3, {5'h0, rv[9:8], 4'h1, 3'h0, k == 3}, 15'h7FF1);
            repeat (5) @(posedge CLK);
            DROP <= 3'h0;
            LEVELS[2] <= 1'b0;
            note(3, 15'h0010, 15'h0010);
            repeat (3) @(posedge CLK);
            MAIN_ENABLE <= 1'b0;
            rnd = lfsr(rnd);
            DLY <= rnd[3:0];
            REGULATOR_ENABLE <= rnd[4];
            LEVELS[1] <= rnd[5];
            LEVELS[0] <= rnd[6];
            note(3, 15'h0000, 15'h0011);
            repeat (3) @(posedge CLK);
            MAIN_ENABLE <= 1'b1;
            note(3, 15'h4044, 15'h40FF);
            repeat (80) @(posedge CLK);
        end
        $display("fault test done");
        @(posedge CLK);
        LEVELS[3] <= 1'b1;
        note(3, run_val(1'b0), 15'h7F10);
        repeat (3) @(posedge CLK);
        LEVELS[3] <= 1'b0;
        note(3, run_val(1'b1), 15'h7F10);
        repeat (3) @(posedge CLK);
        NRST <= 1'b0;
        note(1, 15'h0000, 15'h7FFF);
        @(posedge CLK);
        NRST <= 1'b1;
        note(3, 15'h4044, 15'h40FF);
        repeat (10) @(posedge CLK);
        $display("overvoltage and lockout test done");
        give_verdict();
    end
endmodule : test_lssfc_ctrl
